// File: hw/ulm_regs.svh
// constants for the usart line-mode block
`ifndef ULM_REGS_SVH
`define ULM_REGS_SVH
`define ULM_MODE_W        4
`define ULM_MODE_NORMAL   4'h0
`define ULM_MODE_RS485    4'h1
`define ULM_MODE_HANDSHK  4'h2
`define ULM_MODE_MODEM    4'h3
`define ULM_MODE_IRDA     4'h8
`define ULM_CHMODE_W      2
`define ULM_CH_NORMAL     2'h0
`define ULM_CH_ECHO       2'h1
`define ULM_CH_LOCAL      2'h2
`define ULM_CH_REMOTE     2'h3
`define ULM_FILT_W        8
`define ULM_FILT_RST      8'h00
`define ULM_BIT_CNT_W     16
`define ULM_MIN_BIT_CYC   16'h0001
`define ULM_CLK_HZ        20000000
`define ULM_IR_ERR_PPM    18700
`endif

// File: hw/ulm_pkg.sv
// types for the usart line-mode block
package ulm_pkg;
  typedef enum logic [1:0] {
    ULM_IR_IDLE,
    ULM_IR_COUNT,
    ULM_IR_HOLD
  } ulm_ir_state_e;
endpackage : ulm_pkg

// File: hw/ulm_sync2.sv
// two-flop synchroniser for a bank of pin inputs
`timescale 1ns/1ps
module ulm_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= INIT;
      dout   <= INIT;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : ulm_sync2

// File: hw/ulm_ir_filter.sv
// infrared receive demodulator filter
`timescale 1ns/1ps
`include "ulm_regs.svh"
module ulm_ir_filter #(
  parameter int FW = `ULM_FILT_W,
  parameter int BW = `ULM_BIT_CNT_W
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          enable,
  input  wire logic          rx_s,
  input  wire logic [FW-1:0] filter_value,
  input  wire logic [BW-1:0] bit_cycles,
  output logic               rx_demod
);
  ulm_pkg::ulm_ir_state_e state_q;
  logic [FW-1:0] cnt_q;
  logic [BW-1:0] hold_q;
  logic          prev_q;
  logic          fall;
  logic          rise;

  assign fall = prev_q & ~rx_s;
  assign rise = ~prev_q & rx_s;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prev_q <= 1'b1;
    else
      prev_q <= rx_s;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q  <= ulm_pkg::ULM_IR_IDLE;
      cnt_q    <= FW'(`ULM_FILT_RST);
      hold_q   <= '0;
      rx_demod <= 1'b1;
    end
    else if (!enable)
    begin
      state_q  <= ulm_pkg::ULM_IR_IDLE;
      cnt_q    <= filter_value;
      rx_demod <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        ulm_pkg::ULM_IR_IDLE:
        begin
          rx_demod <= 1'b1;
          cnt_q <= filter_value;
          if (fall)
            state_q <= ulm_pkg::ULM_IR_COUNT;
        end
        ulm_pkg::ULM_IR_COUNT:
        begin
          if (rise)
          begin
            cnt_q   <= filter_value;
            state_q <= ulm_pkg::ULM_IR_IDLE;
          end
          else if (cnt_q == '0)
          begin
            rx_demod <= 1'b0;
            hold_q   <= (bit_cycles == '0) ? BW'(`ULM_MIN_BIT_CYC) : bit_cycles;
            state_q  <= ulm_pkg::ULM_IR_HOLD;
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
        ulm_pkg::ULM_IR_HOLD:
        begin
          if (hold_q == BW'(`ULM_MIN_BIT_CYC))
          begin
            rx_demod <= 1'b1;
            cnt_q    <= filter_value;
            state_q  <= ulm_pkg::ULM_IR_IDLE;
          end
          else
            hold_q <= hold_q - 1'b1;
        end
        default:
          state_q <= ulm_pkg::ULM_IR_IDLE;
      endcase
    end
  end
endmodule : ulm_ir_filter

// File: hw/ulm_line.sv
// usart line modes: infrared filter, rs485, modem control, test routings
// What this block does
// - infrared filter uses 8-bit down counter loaded from filter register
// - falling receive edge starts counter decrementing each master clock
// - rising edge while counting halts and reloads the counter
// - counter reaching zero forces receiver input low one bit period
// - mode 0x1 selects rs485, framing otherwise unchanged
// - in rs485 rts equals inverse of transmitter empty
// - in rs485 rts stays high through trailing timeguard
// - mode 0x3 selects modem; device drives terminal ready and rts
// - deassert command drives terminal ready high, assert command drives low
// - in modem mode rts follows transmitter state automatically
// - in modem mode input level changes set matching sticky change flags
// - channel status read clears all four change flags, except one set by a change in the read cycle
// - in modem mode clear-to-send high disables transmitter after current character
// - normal routing: rx pin to receiver, transmitter to tx pin
// - echo routing copies rx pin to tx pin, receiver still runs
// - local loopback feeds transmitter to receiver, tx pin idles high
// - remote loopback routes rx pin to tx pin, both engines disabled
// - mode 0x8 selects infrared, enabling demodulator before receiver
`timescale 1ns/1ps
`include "ulm_regs.svh"
module ulm_line #(
  parameter int FW = `ULM_FILT_W,
  parameter int BW = `ULM_BIT_CNT_W
) (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic [`ULM_MODE_W-1:0]  op_mode,
  input  wire logic [`ULM_CHMODE_W-1:0] ch_mode,
  input  wire logic [FW-1:0]           infrared_filter_register,
  input  wire logic [BW-1:0]           bit_cycles,
  input  wire logic                    terminal_ready_assert_cmd,
  input  wire logic                    terminal_ready_deassert_cmd,
  input  wire logic                    rts_assert_cmd,
  input  wire logic                    rts_deassert_cmd,
  input  wire logic                    channel_status_read,
  input  wire logic                    transmitter_empty_flag,
  input  wire logic                    timeguard_active,
  input  wire logic                    tx_char_busy,
  input  wire logic                    tx_core_out,
  input  wire logic                    rx_pin,
  input  wire logic                    ri_n_pin,
  input  wire logic                    dsr_n_pin,
  input  wire logic                    dcd_n_pin,
  input  wire logic                    cts_n_pin,
  output logic                         tx_pin,
  output logic                         rx_core_in,
  output logic                         rts_n_pin,
  output logic                         dtr_n_pin,
  output logic                         tx_allow,
  output logic                         rx_allow,
  output logic                         ring_change_flag,
  output logic                         data_set_change_flag,
  output logic                         carrier_change_flag,
  output logic                         clear_to_send_change_flag,
  output logic [3:0]                   modem_levels
);
  logic       rx_s;
  logic [3:0] mdm_s;
  logic [3:0] mdm_prev_q;
  logic [3:0] chg_q;
  logic [3:0] chg_set;
  logic       rx_filt;
  logic       rx_line;
  logic       is_irda;
  logic       is_modem;
  logic       is_rs485;
  logic       rts_sw_q;
  logic       dtr_q;
  logic       tx_q;
  logic       rxi_q;
  logic       cts_gate_q;

  assign is_irda  = (op_mode == `ULM_MODE_IRDA);
  assign is_modem = (op_mode == `ULM_MODE_MODEM);
  assign is_rs485 = (op_mode == `ULM_MODE_RS485);

  // pins are asynchronous: two flops each before use
  ulm_sync2 #(
    .W    (1),
    .INIT (1'b1)
  ) u_rx_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  (rx_pin),
    .dout (rx_s)
  );

  ulm_sync2 #(
    .W    (4),
    .INIT (4'hF)
  ) u_mdm_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  ({cts_n_pin, dcd_n_pin, dsr_n_pin, ri_n_pin}),
    .dout (mdm_s)
  );

  // demodulator active only in infrared mode
  ulm_ir_filter #(
    .FW (FW),
    .BW (BW)
  ) u_ir (
    .clk          (clk),
    .nrst         (nrst),
    .enable       (is_irda),
    .rx_s         (rx_s),
    .filter_value (infrared_filter_register),
    .bit_cycles   (bit_cycles),
    .rx_demod     (rx_filt)
  );

  assign rx_line = is_irda ? rx_filt : rx_s;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mdm_prev_q <= 4'hF;
    else
      mdm_prev_q <= mdm_s;
  end

  assign chg_set = is_modem ? (mdm_prev_q ^ mdm_s) : 4'h0;

  // sticky change flags; set wins over read clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      chg_q <= 4'h0;
    else if (channel_status_read)
      chg_q <= chg_set;
    else
      chg_q <= chg_q | chg_set;
  end

  assign ring_change_flag          = chg_q[0];
  assign data_set_change_flag      = chg_q[1];
  assign carrier_change_flag       = chg_q[2];
  assign clear_to_send_change_flag = chg_q[3];
  assign modem_levels              = mdm_prev_q;

  // terminal ready commands, deassert wins on conflict
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dtr_q <= 1'b1;
    else if (terminal_ready_deassert_cmd)
      dtr_q <= 1'b1;
    else if (terminal_ready_assert_cmd)
      dtr_q <= 1'b0;
  end
  assign dtr_n_pin = dtr_q;

  // software rts level for modes with no automatic control
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rts_sw_q <= 1'b1;
    else if (rts_deassert_cmd)
      rts_sw_q <= 1'b1;
    else if (rts_assert_cmd)
      rts_sw_q <= 1'b0;
  end

  // rs485 rts is inverse of empty flag, or high in timeguard
  // modem rts is active low while transmitter busy
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rts_n_pin <= 1'b1;
    else if (is_rs485)
      rts_n_pin <= ~transmitter_empty_flag | timeguard_active;
    else if (is_modem)
      rts_n_pin <= transmitter_empty_flag;
    else
      rts_n_pin <= rts_sw_q;
  end

  // cts high blocks only at character boundary
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cts_gate_q <= 1'b1;
    else if (!is_modem)
      cts_gate_q <= 1'b1;
    else if (!tx_char_busy)
      cts_gate_q <= ~mdm_s[3];
  end

  assign rx_allow = (ch_mode != `ULM_CH_REMOTE);
  assign tx_allow = (ch_mode != `ULM_CH_REMOTE) & cts_gate_q;

  // pin routing registered so outputs come from flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_q  <= 1'b1;
      rxi_q <= 1'b1;
    end
    else
    begin
      unique case (ch_mode)
        `ULM_CH_NORMAL:
        begin
          tx_q  <= tx_core_out;
          rxi_q <= rx_line;
        end
        // echo rx to tx, receiver live
        `ULM_CH_ECHO:
        begin
          tx_q  <= rx_s;
          rxi_q <= rx_line;
        end
        `ULM_CH_LOCAL:
        begin
          tx_q  <= 1'b1;
          rxi_q <= tx_core_out;
        end
        `ULM_CH_REMOTE:
        begin
          tx_q  <= rx_s;
          rxi_q <= 1'b1;
        end
      endcase
    end
  end

  assign tx_pin     = tx_q;
  assign rx_core_in = rxi_q;
endmodule : ulm_line

// File: tb/ulm_modem_model.sv
// far-side stand-in for the modem and the receive line
`timescale 1ns/1ps
module ulm_modem_model (
  input  wire logic       clk,
  input  wire logic       rx_lvl,
  input  wire logic [3:0] mdm_lvl,
  output logic            rx_pin,
  output logic            ri_n_pin,
  output logic            dsr_n_pin,
  output logic            dcd_n_pin,
  output logic            cts_n_pin
);
  // lines move a little after the edge, never on it
  always @(posedge clk) {cts_n_pin, dcd_n_pin, dsr_n_pin, ri_n_pin, rx_pin} <= #2 {mdm_lvl, rx_lvl};
endmodule : ulm_modem_model

// File: tb/ulm_line_asserts.sv
// port assertions for the line-mode block
`timescale 1ns/1ps
`include "ulm_regs.svh"
module ulm_line_chk (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [3:0] op_mode,
  input wire logic [1:0] ch_mode,
  input wire logic       terminal_ready_assert_cmd,
  input wire logic       terminal_ready_deassert_cmd,
  input wire logic       channel_status_read,
  input wire logic       transmitter_empty_flag,
  input wire logic       timeguard_active,
  input wire logic       tx_char_busy,
  input wire logic       tx_core_out,
  input wire logic       tx_pin,
  input wire logic       rts_n_pin,
  input wire logic       dtr_n_pin,
  input wire logic       tx_allow,
  input wire logic       rx_allow,
  input wire logic       ring_change_flag,
  input wire logic       data_set_change_flag,
  input wire logic       carrier_change_flag,
  input wire logic       clear_to_send_change_flag,
  input wire logic [3:0] modem_levels
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  dtr_off_a: assert property (terminal_ready_deassert_cmd |=> dtr_n_pin)
    else $error("dtr not released");
  dtr_on_a: assert property (terminal_ready_assert_cmd && !terminal_ready_deassert_cmd |=> !dtr_n_pin)
    else $error("dtr not asserted");
  rts_485_a: assert property (op_mode == `ULM_MODE_RS485 |=>
    rts_n_pin == (!$past(transmitter_empty_flag) || $past(timeguard_active))) else $error("rs485 rts wrong");
  rts_modem_a: assert property (op_mode == `ULM_MODE_MODEM |=> rts_n_pin == $past(transmitter_empty_flag))
    else $error("modem rts wrong");
  local_idle_a: assert property (ch_mode == `ULM_CH_LOCAL |=> tx_pin)
    else $error("tx pin not idle");
  normal_tx_a: assert property (op_mode == `ULM_MODE_NORMAL && ch_mode == `ULM_CH_NORMAL |=>
    tx_pin == $past(tx_core_out)) else $error("tx pin not from core");
  remote_off_a: assert property (ch_mode == `ULM_CH_REMOTE |-> !tx_allow && !rx_allow)
    else $error("transmitter not off");
  cts_flag_a: assert property (op_mode == `ULM_MODE_MODEM && $changed(modem_levels[3]) |-> ##[0:1]
    clear_to_send_change_flag) else $error("cts change missed");
  // only a change landing on the read edge may survive it
  read_clr_a: assert property (channel_status_read |=>
    {clear_to_send_change_flag, carrier_change_flag, data_set_change_flag, ring_change_flag} ==
    (($past(op_mode) == `ULM_MODE_MODEM) ? (modem_levels ^ $past(modem_levels)) : 4'h0))
    else $error("flags not cleared");
  char_done_a: assert property (op_mode == `ULM_MODE_MODEM && tx_char_busy && tx_allow |=> tx_allow)
    else $error("character cut short");
endmodule : ulm_line_chk
bind ulm_line ulm_line_chk u_ulm_line_chk (.clk, .nrst, .op_mode, .ch_mode, .terminal_ready_assert_cmd,
  .terminal_ready_deassert_cmd, .channel_status_read, .transmitter_empty_flag, .timeguard_active, .tx_char_busy,
  .tx_core_out, .tx_pin, .rts_n_pin, .dtr_n_pin, .tx_allow, .rx_allow, .ring_change_flag, .data_set_change_flag,
  .carrier_change_flag, .clear_to_send_change_flag, .modem_levels);

// File: tb/tb_usart_line_modes_irda_rs485_modem.sv
// self-checking bench for the line-mode block
`timescale 1ns/1ps
`include "ulm_regs.svh"
module tb_usart_line_modes_irda_rs485_modem;
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] ch;
    logic       txo, emp, tg, rx, e_tx, e_rts, e_rxc;
  } ulm_row_s;
  logic        clk = 1'b0, nrst = 1'b0, tx_core_out = 1'b1, rx_lvl = 1'b1, tx_char_busy = 1'b0;
  logic        transmitter_empty_flag = 1'b1, timeguard_active = 1'b0;
  logic [3:0]  op_mode = 4'h0, mdm_lvl = 4'hF, modem_levels;
  logic [1:0]  ch_mode = 2'h0;
  logic [4:0]  cmds = 5'h00;
  logic [7:0]  infrared_filter_register = 8'h04;
  // divisor gives an exact rate here
  logic [15:0] bit_cycles = 16'h000A;
  logic        rx_pin, ri_n_pin, dsr_n_pin, dcd_n_pin, cts_n_pin, tx_pin, rx_core_in, rts_n_pin, dtr_n_pin;
  logic        tx_allow, ring_change_flag, data_set_change_flag, carrier_change_flag, clear_to_send_change_flag;
  logic        rx_allow;
  wire         terminal_ready_assert_cmd, terminal_ready_deassert_cmd, rts_assert_cmd, rts_deassert_cmd;
  wire         channel_status_read;
  wire  [3:0]  flags = {clear_to_send_change_flag, carrier_change_flag, data_set_change_flag, ring_change_flag};
  int          errors = 0, n_checks = 0, lows;
  ulm_row_s    rows [11] = '{13'h02B, 13'h066, 13'h12E, 13'h0AF, 13'h0E2, 13'h1E3, 13'h24F, 13'h27F, 13'h26D,
                            13'h64D, 13'h66F};
  logic [6:0]  ctab [5] = '{7'h41, 7'h63, 7'h41, 7'h10, 7'h09};
  assign {terminal_ready_assert_cmd, terminal_ready_deassert_cmd, rts_assert_cmd, rts_deassert_cmd,
          channel_status_read} = cmds;
  ulm_line u_ulm_line (.clk, .nrst, .op_mode, .ch_mode, .infrared_filter_register, .bit_cycles,
    .terminal_ready_assert_cmd, .terminal_ready_deassert_cmd, .rts_assert_cmd, .rts_deassert_cmd,
    .channel_status_read, .transmitter_empty_flag, .timeguard_active, .tx_char_busy, .tx_core_out, .rx_pin,
    .ri_n_pin, .dsr_n_pin, .dcd_n_pin, .cts_n_pin, .tx_pin, .rx_core_in, .rts_n_pin, .dtr_n_pin, .tx_allow,
    .rx_allow, .ring_change_flag, .data_set_change_flag, .carrier_change_flag, .clear_to_send_change_flag,
    .modem_levels);
  ulm_modem_model u_ulm_modem_model (.clk, .rx_lvl, .mdm_lvl, .rx_pin, .ri_n_pin, .dsr_n_pin, .dcd_n_pin,
    .cts_n_pin);
  always #25 clk = ~clk;
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic pulse(input logic [4:0] c);
    @(posedge clk) cmds <= c;
    @(posedge clk) cmds <= 5'h00;
    tick(2);
  endtask : pulse
  // low cycles seen by the receiver for one low pulse of len cycles
  task automatic ir(input int len, input int exp);
    lows = 0;
    @(posedge clk) rx_lvl <= 1'b0;
    for (int k = 1; k < 40; k++)
    begin
      @(posedge clk);
      if (k == len)
        rx_lvl <= 1'b1;
      #1 lows += int'(rx_core_in === 1'b0);
    end
    chk("low cycles", lows[7:0], exp[7:0]);
  endtask : ir
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (4000) @(posedge clk);
    errors++;
    summarize();
  end
  initial
  begin
    tick(16);
    chk("reset pins", {tx_pin, rx_core_in, rts_n_pin, dtr_n_pin, modem_levels}, 8'hFF);
    chk("reset flags", flags, 8'h00);
    @(posedge clk) nrst <= 1'b1;
    $display("test reset done");
    foreach (rows[i])
    begin
      @(posedge clk) {op_mode, ch_mode, tx_core_out, transmitter_empty_flag, timeguard_active, rx_lvl} <= rows[i][12:3];
      tick(6);
      chk("tx rts rx", {tx_pin, rts_n_pin, rx_core_in}, rows[i][2:0]);
      chk("rx allow", rx_allow, {7'h00, rows[i].ch != `ULM_CH_REMOTE});
    end
    $display("test routing done");
    @(posedge clk) op_mode <= `ULM_MODE_NORMAL;
    foreach (ctab[i])
    begin
      pulse(ctab[i][6:2]);
      chk("dtr rts", {dtr_n_pin, rts_n_pin}, ctab[i][1:0]);
    end
    $display("test commands done");
    @(posedge clk) op_mode <= `ULM_MODE_MODEM;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk) mdm_lvl[i] <= 1'b0;
      tick(5);
      chk("change flags", flags, 8'h01 << i);
      pulse(5'h01);
      chk("flags cleared", flags, 8'h00);
    end
    @(posedge clk) op_mode <= `ULM_MODE_NORMAL;
    mdm_lvl[3] <= 1'b1;
    tick(5);
    chk("no flags outside modem", flags, 8'h00);
    @(posedge clk) op_mode <= `ULM_MODE_MODEM;
    tick(4);
    chk("cts blocks", tx_allow, 8'h00);
    @(posedge clk) mdm_lvl[3] <= 1'b0;
    tick(5);
    chk("cts allows", tx_allow, 8'h01);
    @(posedge clk) tx_char_busy <= 1'b1;
    mdm_lvl[3] <= 1'b1;
    tick(5);
    chk("char finishes", tx_allow, 8'h01);
    @(posedge clk) tx_char_busy <= 1'b0;
    tick(3);
    chk("cts blocks after char", tx_allow, 8'h00);
    $display("test modem done");
    // mid-run reset with a sticky flag and terminal ready asserted
    @(posedge clk) nrst <= 1'b0;
    mdm_lvl <= 4'hF;
    tick(2);
    chk("mid reset pins", {tx_pin, rx_core_in, rts_n_pin, dtr_n_pin, modem_levels}, 8'hFF);
    chk("mid reset flags", {tx_allow, flags}, 8'h10);
    @(posedge clk) nrst <= 1'b1;
    tick(6);
    chk("after reset", {dtr_n_pin, flags}, 8'h10);
    $display("test mid reset done");
    @(posedge clk) op_mode <= `ULM_MODE_IRDA;
    tick(3);
    ir(2, 0);
    ir(20, 10);
    @(posedge clk) infrared_filter_register <= 8'h0C;
    ir(8, 0);
    @(posedge clk) op_mode <= `ULM_MODE_NORMAL;
    ir(3, 3);
    $display("test infrared done");
    summarize();
  end
endmodule : tb_usart_line_modes_irda_rs485_modem
